// File: hdl/codec_serial_port.sv
// codec serial port: frame timing, sample-rate counters and fifo movement
`timescale 1ns/100ps
module codec_serial_port (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // codec link pins
  output logic             serial_clk,
  output logic             frame_sync_pulse,
  output logic             port_transmit_line,
  input  wire logic        port_receive_line,
  // receive fifo service requests
  output logic             audio_rx_req,
  output logic             telecom_rx_req
);
  import codec_port_pkg::*;

  typedef struct packed {
    logic                  ack;
    logic [31:0]           rdat;
    logic [6:0]            aud_div;
    logic [6:0]            tel_div;
    logic                  port_en;
    logic                  ign_valid;
    logic [20:0]           cmd;
    logic [20:0]           cmd_rx;
    logic                  rx_meta;
    logic                  rx_sync;
    logic [3:0]            half_cnt;
    logic                  sclk;
    logic                  fs;
    logic                  txd;
    logic [6:0]            bit_cnt;
    logic [63:0]           sh;
    logic [1:0]            en_stat;
    logic [1:0]            en_next;
    logic [1:0]            run;
    logic [1:0]            overrun;
    logic [1:0]            got_first;
    logic [1:0]            conv_due;
    logic [1:0]            req;
    logic [1:0][11:0]      cnt;
    logic [1:0][15:0]      tx_hold;
  } port_st_t;

  port_st_t         s_r;
  port_st_t         s_nxt;

  // per-section fifo wiring: index 0 audio, 1 telecom
  logic [1:0]       tx_push;
  logic [1:0]       tx_pop;
  logic [1:0]       rx_push;
  logic [1:0]       rx_pop;
  logic [1:0][15:0] rx_data;
  logic [1:0][15:0] tx_head;
  logic [1:0][15:0] rx_head;
  logic [1:0][3:0]  tx_lvl;
  logic [1:0][3:0]  rx_lvl;
  logic [1:0]       tx_full;
  logic [1:0]       tx_empty;
  logic [1:0]       rx_full;
  logic [1:0]       rx_empty;
  logic [1:0][11:0] modulus;
  logic [1:0]       valid_bit;
  logic [1:0][15:0] rx_field;
  logic [1:0]       capture;
  logic [6:0]       adiv;
  logic [6:0]       tdiv;
  logic             req_hit;
  logic             wr_ok;
  logic             rise;
  logic             fall;
  logic [6:0]       nb;
  logic [1:0]       ovr_set;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sect
      // transmit fifos 8 deep, receive fifos 12 deep
      sample_fifo #(.WIDTH(16), .DEPTH(TX_DEPTH), .LW(LVL_W)) u_tx (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .push      (tx_push[g]),
        .push_data (wb_dat_i[15:0]),
        .pop       (tx_pop[g]),
        .head      (tx_head[g]),
        .level     (tx_lvl[g]),
        .full      (tx_full[g]),
        .empty     (tx_empty[g])
      );
      sample_fifo #(.WIDTH(16), .DEPTH(RX_DEPTH), .LW(LVL_W)) u_rx (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .push      (rx_push[g]),
        .push_data (rx_data[g]),
        .pop       (rx_pop[g]),
        .head      (rx_head[g]),
        .level     (rx_lvl[g]),
        .full      (rx_full[g]),
        .empty     (rx_empty[g])
      );
    end
  endgenerate

  // divisors below the section minimum are clamped up
  assign adiv = (s_r.aud_div < AUD_DIV_MIN) ? AUD_DIV_MIN : s_r.aud_div;
  assign tdiv = (s_r.tel_div < TEL_DIV_MIN) ? TEL_DIV_MIN : s_r.tel_div;
  // counter runs 0..32*div-1, so one period is 32*div bit clocks
  assign modulus[0] = 12'(FIXED_DIV * adiv - 1);
  assign modulus[1] = 12'(FIXED_DIV * tdiv - 1);

  always_comb begin
    s_nxt    = s_r;
    tx_push  = '0;
    tx_pop   = '0;
    rx_push  = '0;
    rx_pop   = '0;
    rx_data  = '0;
    capture  = '0;
    ovr_set  = '0;
    req_hit  = wb_cyc_i && wb_stb_i && !s_r.ack;
    wr_ok    = req_hit && wb_we_i && (wb_sel_i == 4'hf);
    rise     = 1'b0;
    fall     = 1'b0;
    nb       = s_r.bit_cnt + 7'h01;
    valid_bit[0] = s_r.sh[AV_POS];
    valid_bit[1] = s_r.sh[TV_POS];
    // received samples are forced to their justified width
    rx_field[0] = s_r.sh[AUD_MSB:AUD_LSB] & AUD_MASK;
    rx_field[1] = s_r.sh[TEL_MSB:TEL_LSB] & TEL_MASK;

    // request while 5..12 entries, dropped once reads go below
    // computed first so the status word shows the same level and request
    for (int i = 0; i < 2; i++) begin
      s_nxt.req[i] = (rx_lvl[i] >= RX_REQ_LEVEL);
    end

    // wishbone: ack one cycle after the request, dropped the next cycle
    s_nxt.ack = req_hit;
    if (req_hit) begin
      s_nxt.rdat = 32'h0;
      unique case (wb_adr_i)
        ADR_CTRL: begin
          s_nxt.rdat = {14'h0, s_r.ign_valid, s_r.port_en, 1'b0, s_r.tel_div,
                        1'b0, s_r.aud_div};
          if (wr_ok) begin
            s_nxt.aud_div   = wb_dat_i[CTL_ADIV_LSB +: 7];
            s_nxt.tel_div   = wb_dat_i[CTL_TDIV_LSB +: 7];
            s_nxt.port_en   = wb_dat_i[CTL_EN_BIT];
            s_nxt.ign_valid = wb_dat_i[CTL_IGN_BIT];
          end
        end
        ADR_AUDIO, ADR_TELCOM: begin
          if (wb_we_i) begin
            tx_push[wb_adr_i == ADR_TELCOM] = wr_ok;
          end else begin
            s_nxt.rdat = {16'h0, rx_head[wb_adr_i == ADR_TELCOM]};
            rx_pop[wb_adr_i == ADR_TELCOM] = 1'b1;
          end
        end
        ADR_CODEC: begin
          s_nxt.rdat = {11'h0, s_r.cmd_rx};
          if (wr_ok) begin
            s_nxt.cmd = wb_dat_i[20:0];
          end
        end
        ADR_STATUS: begin
          s_nxt.rdat = {8'h0, rx_lvl[1], rx_lvl[0], 6'h0, rx_empty, tx_full,
                        s_r.overrun, s_nxt.req, s_r.en_stat};
          if (wr_ok) begin
            s_nxt.overrun = s_r.overrun & ~wb_dat_i[5:4];
          end
        end
        default: s_nxt.rdat = 32'h0;
      endcase
    end

    // receive pin synchroniser
    s_nxt.rx_meta = port_receive_line;
    s_nxt.rx_sync = s_r.rx_meta;

    // bit clock divider; the link toggles only while the port is enabled
    if (!s_r.port_en) begin
      s_nxt.half_cnt = '0;
      s_nxt.sclk     = 1'b0;
      s_nxt.fs       = 1'b0;
      s_nxt.txd      = 1'b0;
      s_nxt.bit_cnt  = FRAME_PRE_BIT;
    end else if (s_r.half_cnt == SCLK_HALF_LAST) begin
      s_nxt.half_cnt = '0;
      s_nxt.sclk     = !s_r.sclk;
      rise           = !s_r.sclk;
      fall           = s_r.sclk;
    end else begin
      s_nxt.half_cnt = s_r.half_cnt + 4'h1;
    end

    // sample receive data on the falling edge during subframe 0
    if (fall && s_r.bit_cnt < SUB0_BITS) begin
      s_nxt.sh = {s_r.sh[62:0], s_r.rx_sync};
    end

    if (rise) begin
      s_nxt.bit_cnt = nb;
      // sync high for the last bit clock of the frame
      s_nxt.fs  = (nb == FRAME_LAST_BIT);
      // line held low outside subframe 0
      s_nxt.txd = (nb < SUB0_BITS) ? s_r.sh[63] : 1'b0;

      for (int i = 0; i < 2; i++) begin
        if (!s_r.run[i]) begin
          s_nxt.cnt[i] = modulus[i];
        end else if (s_r.cnt[i] == 12'h0) begin
          // reload at zero marks a conversion in lock-step with the codec
          s_nxt.cnt[i]      = modulus[i];
          s_nxt.conv_due[i] = 1'b1;
          // next entry, or the old value again if nothing new is queued
          if (!tx_empty[i]) begin
            s_nxt.tx_hold[i] = tx_head[i];
            tx_pop[i]        = 1'b1;
          end
        end else begin
          s_nxt.cnt[i] = s_r.cnt[i] - 12'h001;
        end
      end

      if (nb == FRAME_LAST_BIT) begin
        // frame load at the sync rising edge; held values resent each frame
        s_nxt.sh = {s_r.tx_hold[0], 1'b0, s_r.cmd[19:16], s_r.cmd[20], 8'h00,
                    s_r.en_stat[0], s_r.en_stat[1], s_r.tx_hold[1],
                    s_r.cmd[15:0]};
        // enable writes sent in this frame take effect after subframe 0
        if (s_r.cmd[20] && s_r.cmd[19:16] == CODEC_EN_ADDR) begin
          s_nxt.en_next[0] = s_r.cmd[AUD_IN_EN_BIT] | s_r.cmd[AUD_OUT_EN_BIT];
          s_nxt.en_next[1] = s_r.cmd[TEL_IN_EN_BIT] | s_r.cmd[TEL_OUT_EN_BIT];
        end
        // counters start or stop on the sync after the codec register changed
        for (int i = 0; i < 2; i++) begin
          s_nxt.run[i] = s_r.en_stat[i];
          if (!s_r.en_stat[i]) begin
            s_nxt.cnt[i] = modulus[i];
          end
        end
      end

      if (nb == SUB0_BITS) begin
        // shifter now holds the received subframe 0
        s_nxt.cmd_rx = {s_r.sh[RW_POS], s_r.sh[ADDR_MSB:ADDR_LSB],
                        s_r.sh[CDAT_MSB:0]};
        for (int i = 0; i < 2; i++) begin
          // codec register updates at end of subframe 0, as does our copy
          s_nxt.en_stat[i] = s_r.en_next[i];
          if (s_r.en_next[i] && !s_r.en_stat[i]) begin
            s_nxt.cnt[i] = modulus[i];
            if (!tx_empty[i]) begin
              s_nxt.tx_hold[i] = tx_head[i];
              tx_pop[i]        = 1'b1;
            end
          end
          if (!s_r.en_stat[i]) begin
            s_nxt.got_first[i] = 1'b0;
            s_nxt.conv_due[i]  = 1'b0;
          end
          // after the first stored sample the counter may replace the valid bit
          if (s_r.ign_valid && s_r.got_first[i]) begin
            capture[i] = s_r.en_stat[i] && s_r.conv_due[i];
          end else begin
            capture[i] = s_r.en_stat[i] && valid_bit[i];
          end
          if (capture[i]) begin
            s_nxt.got_first[i] = 1'b1;
            s_nxt.conv_due[i]  = 1'b0;
            rx_data[i]         = rx_field[i];
            rx_push[i]         = 1'b1;
            ovr_set[i]         = rx_full[i];
          end
        end
      end
    end

    // an overrun in the clearing cycle still sets the flag
    s_nxt.overrun = s_nxt.overrun | ovr_set;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_r         <= '0;
      s_r.aud_div <= AUD_DIV_RST;
      s_r.tel_div <= TEL_DIV_RST;
      s_r.bit_cnt <= FRAME_PRE_BIT;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_ack_o           = s_r.ack;
  assign wb_dat_o           = s_r.rdat;
  assign serial_clk         = s_r.sclk;
  assign frame_sync_pulse   = s_r.fs;
  assign port_transmit_line = s_r.txd;
  assign audio_rx_req       = s_r.req[0];
  assign telecom_rx_req     = s_r.req[1];

endmodule : codec_serial_port

// File: hdl/codec_port_pkg.sv
// constants shared by the codec serial port sample-rate and fifo logic
package codec_port_pkg;

  // bit clock derived from core_clk (125 MHz)
  localparam int CLK_PERIOD_NS  = 8;
  localparam int SCLK_HALF_NS   = 48;
  localparam int SCLK_HALF_CYC  = SCLK_HALF_NS / CLK_PERIOD_NS;
  localparam logic [3:0] SCLK_HALF_LAST = 4'(SCLK_HALF_CYC - 1);

  // frame layout, bit counter positions
  localparam logic [6:0] FRAME_LAST_BIT = 7'h7f;
  localparam logic [6:0] FRAME_PRE_BIT  = 7'h7e;
  localparam logic [6:0] SUB0_BITS      = 7'h40;
  localparam int AUD_MSB  = 63;
  localparam int AUD_LSB  = 48;
  localparam int ADDR_MSB = 46;
  localparam int ADDR_LSB = 43;
  localparam int RW_POS   = 42;
  localparam int AV_POS   = 33;
  localparam int TV_POS   = 32;
  localparam int TEL_MSB  = 31;
  localparam int TEL_LSB  = 16;
  localparam int CDAT_MSB = 15;

  // sample widths, left justified in 16 bits
  localparam logic [15:0] AUD_MASK = 16'hfff0;
  localparam logic [15:0] TEL_MASK = 16'hfffc;

  // sample-rate divisors
  localparam int FIXED_DIV = 32;
  localparam logic [6:0] AUD_DIV_MIN = 7'h06;
  localparam logic [6:0] TEL_DIV_MIN = 7'h10;
  localparam logic [6:0] DIV_MAX     = 7'h7f;
  localparam logic [6:0] AUD_DIV_RST = 7'h0c;
  localparam logic [6:0] TEL_DIV_RST = 7'h10;

  // fifos
  localparam int TX_DEPTH = 8;
  localparam int RX_DEPTH = 12;
  localparam int LVL_W    = 4;
  localparam logic [3:0] RX_REQ_LEVEL = 4'h5;

  // codec enable register as seen in outgoing control writes
  localparam logic [3:0] CODEC_EN_ADDR = 4'h8;
  localparam int AUD_IN_EN_BIT  = 15;
  localparam int AUD_OUT_EN_BIT = 14;
  localparam int TEL_IN_EN_BIT  = 13;
  localparam int TEL_OUT_EN_BIT = 12;

  // register word offsets (byte addresses)
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_AUDIO  = 8'h04;
  localparam logic [7:0] ADR_TELCOM = 8'h08;
  localparam logic [7:0] ADR_CODEC  = 8'h0c;
  localparam logic [7:0] ADR_STATUS = 8'h10;

  // control register fields
  localparam int CTL_ADIV_LSB = 0;
  localparam int CTL_TDIV_LSB = 8;
  localparam int CTL_EN_BIT   = 16;
  localparam int CTL_IGN_BIT  = 17;

endpackage : codec_port_pkg

// File: hdl/sample_fifo.sv
// synchronous sample fifo with occupancy level
`timescale 1ns/100ps
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int LW    = 4
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // fill side
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  // drain side
  input  wire logic             pop,
  output logic      [WIDTH-1:0] head,
  // occupancy
  output logic      [LW-1:0]    level,
  output logic                  full,
  output logic                  empty
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [LW-1:0]               rd;
    logic [LW-1:0]               wr;
    logic [LW-1:0]               cnt;
  } fifo_st_t;

  fifo_st_t s_r;
  fifo_st_t s_nxt;
  logic     do_push;
  logic     do_pop;

  assign full  = (s_r.cnt == LW'(DEPTH));
  assign empty = (s_r.cnt == '0);
  assign level = s_r.cnt;
  assign head  = s_r.mem[s_r.rd];

  always_comb begin
    s_nxt   = s_r;
    do_push = push && !full;
    do_pop  = pop && !empty;
    if (do_push) begin
      s_nxt.mem[s_r.wr] = push_data;
      s_nxt.wr = (s_r.wr == LW'(DEPTH - 1)) ? '0 : s_r.wr + 1'b1;
    end
    if (do_pop) begin
      s_nxt.rd = (s_r.rd == LW'(DEPTH - 1)) ? '0 : s_r.rd + 1'b1;
    end
    if (do_push && !do_pop) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (do_pop && !do_push) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : sample_fifo

// File: tb/codec_port_checker.sv
// pin and handshake assertions for the codec serial port
`timescale 1ns/100ps
module codec_port_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // bus handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // link pins
  input wire logic serial_clk,
  input wire logic frame_sync_pulse,
  input wire logic port_transmit_line
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  logic        fs_q;
  logic        seen;
  logic [10:0] gap;

  // cycles since the last sync rise; only trusted once one rise was seen
  always_ff @(posedge core_clk) begin
    fs_q <= frame_sync_pulse;
    gap  <= (frame_sync_pulse && !fs_q) ? 11'h001 : gap + 11'h001;
    seen <= !sys_rst && (seen || (frame_sync_pulse && !fs_q));
  end

  chk_ack_answer: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without a request");
  chk_bit_half: assert property ($rose(serial_clk) |-> serial_clk [*6] ##1 !serial_clk)
    else $error("bit clock high phase wrong");
  chk_sync_width: assert property ($rose(frame_sync_pulse) |->
    frame_sync_pulse [*8] ##1 frame_sync_pulse [*4] ##1 !frame_sync_pulse)
    else $error("sync pulse not one bit long");
  chk_frame_gap: assert property ((frame_sync_pulse && !fs_q && seen) |-> gap == 11'h600)
    else $error("frame not 128 bits long");
  chk_sync_edge: assert property ($rose(frame_sync_pulse) |-> $rose(serial_clk))
    else $error("sync rise apart from bit clock rise");
  chk_line_quiet: assert property (frame_sync_pulse |-> !port_transmit_line)
    else $error("transmit line driven in sync bit");
endmodule : codec_port_checker

// File: tb/codec_model.sv
// behavioural codec on the far side of the serial link, audio section only
`timescale 1ns/100ps
module codec_model #(
  parameter int DIV = 8
) (
  // link pins
  input  wire logic serial_clk,
  input  wire logic frame_sync_pulse,
  input  wire logic port_transmit_line,
  output logic      port_receive_line,
  // valid bit policy
  input  wire logic sticky
);
  logic [6:0]  pos = 7'h7f;
  logic [63:0] rx_sh = '0;
  logic [63:0] tx_sh = '0;
  logic [15:0] rx_aud = '0;
  logic [11:0] cnt = '0;
  logic [11:0] smp = '0;
  logic        en = 1'b0;
  logic        run = 1'b0;
  logic        av = 1'b0;
  logic [15:0] conv[$];

  initial port_receive_line = 1'b0;

  // line driven low outside subframe 0 rather than left floating
  always @(posedge serial_clk)
    port_receive_line <= !pos[6] && tx_sh[~pos[5:0]];

  // everything settles on the falling edge, so the rising edge sees stable state
  always @(negedge serial_clk) begin
    if (run && cnt == 12'h000) begin
      conv.push_back(rx_aud);
      smp++;
      av = 1'b1;
    end
    cnt = (!run || cnt == 12'h000) ? 12'(32 * DIV - 1) : cnt - 12'h001;
    if (!pos[6])
      rx_sh = {rx_sh[62:0], port_transmit_line};
    if (pos == 7'h3f) begin
      rx_aud = rx_sh[63:48];
      if (rx_sh[46:43] == 4'h8 && rx_sh[42])
        en = |rx_sh[15:14];
    end
    if (frame_sync_pulse) begin
      pos = 7'h00;
      run = en;
      tx_sh = {smp, 4'hf, 14'h0, av, 33'h0};
      av = av && sticky && en;
    end else begin
      pos = pos + 7'h01;
    end
  end
endmodule : codec_model

// File: tb/codec_serial_port_bench.sv
// self-checking bench for the codec serial port
`timescale 1ns/100ps
module codec_serial_port_bench;
  import codec_port_pkg::*;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        serial_clk;
  logic        frame_sync_pulse;
  logic        port_transmit_line;
  logic        port_receive_line;
  logic        audio_rx_req;
  logic        telecom_rx_req;
  logic        sticky = 1'b0;
  int          errors = 0;
  int          comparisons = 0;
  int          n;
  logic [31:0] q;
  logic [3:0]  lvl;
  logic [1:0]  rq;

  codec_serial_port i_codec_serial_port (
    .core_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .serial_clk, .frame_sync_pulse,
    .port_transmit_line, .port_receive_line, .audio_rx_req, .telecom_rx_req
  );
  codec_model #(.DIV(8)) i_codec_model (
    .serial_clk, .frame_sync_pulse, .port_transmit_line, .port_receive_line, .sticky
  );

  always #4 core_clk = ~core_clk;

  task automatic finish_test;
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %h not %h", $time, seen, exp);
    end
  endtask : check

  // one classic cycle; read data lands in q at the ack edge
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge core_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    q = wb_dat_o;
    rq = {telecom_rx_req, audio_rx_req};
    check(wb_ack_o, 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task automatic req_chk;
    bus(1'b0, ADR_STATUS, 32'h0);
    lvl = q[19:16];
    check(q[2], lvl >= 4'h5);
    check(rq[0], lvl >= 4'h5);
    check(rq[1], q[23:20] >= 4'h5);
  endtask : req_chk

  task automatic wait_en(input logic v);
    n = 0;
    do begin
      bus(1'b0, ADR_STATUS, 32'h0);
      n++;
    end while (q[0] !== v && n < 3000);
    check(q[0], v);
  endtask : wait_en

  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    bus(1'b0, ADR_CTRL, 32'h0);
    check(q, 32'h0000100c);
    bus(1'b0, ADR_STATUS, 32'h0);
    check(q, 32'h00000300);
    bus(1'b0, 8'h14, 32'h0);
    check(q, 32'h0);
    // a write without all byte lanes must leave the port disabled
    wb_sel_i <= 4'h3;
    bus(1'b1, ADR_CTRL, 32'h00010000);
    wb_sel_i <= 4'hf;
    bus(1'b0, ADR_CTRL, 32'h0);
    check(q, 32'h0000100c);
    // ninth entry must be dropped, so the repeat value below stays at entry eight
    for (int i = 1; i <= 9; i++) begin
      bus(1'b1, ADR_AUDIO, 32'(i) << 12);
      bus(1'b0, ADR_STATUS, 32'h0);
      check(q[6], i >= 8);
    end
    bus(1'b1, ADR_CODEC, 32'h0018c000);
    bus(1'b1, ADR_CTRL, 32'h00011008);
    bus(1'b0, ADR_CTRL, 32'h0);
    check(q, 32'h00011008);
    wait_en(1'b1);
    n = 0;
    do begin
      req_chk;
      n++;
    end while (lvl < 4'h5 && n < 9000);
    for (int i = 1; i <= 5; i++) begin
      bus(1'b0, ADR_AUDIO, 32'h0);
      check(q[15:0], 32'(i) << 4);
    end
    req_chk;
    n = 0;
    while (i_codec_model.conv.size() < 10 && n < 40000) begin
      @(posedge core_clk);
      n++;
    end
    for (int i = 0; i < 10; i++)
      check(i_codec_model.conv[i], i < 8 ? 32'(i + 1) << 12 : 32'h8000);
    // sticky valid makes the frame after the stopping sync carry a flagged sample
    sticky <= 1'b1;
    bus(1'b1, ADR_CODEC, 32'h00180000);
    wait_en(1'b0);
    // past the stopping sync, yet ahead of the end of subframe 0 in that flagged frame
    repeat (900) @(posedge core_clk);
    req_chk;
    repeat (6144) @(posedge core_clk);
    bus(1'b0, ADR_STATUS, 32'h0);
    check(q[19:16], lvl);
    n = 0;
    while (q[8] !== 1'b1 && n < 16) begin
      bus(1'b0, ADR_AUDIO, 32'h0);
      bus(1'b0, ADR_STATUS, 32'h0);
      n++;
    end
    bus(1'b1, ADR_CTRL, 32'h00031008);
    bus(1'b1, ADR_CODEC, 32'h0018c000);
    wait_en(1'b1);
    repeat (18432) @(posedge core_clk);
    req_chk;
    check(lvl < 4'h8, 1'b1);
    // valid bit honoured again: every flagged frame pushes until the fifo overflows
    bus(1'b1, ADR_CTRL, 32'h00011008);
    repeat (15360) @(posedge core_clk);
    req_chk;
    check(lvl, 4'hc);
    check(q[4], 1'b1);
    finish_test;
  end

  initial begin
    #800000;
    errors++;
    finish_test;
  end
endmodule : codec_serial_port_bench

bind codec_serial_port codec_port_checker i_codec_port_checker (
  .core_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .serial_clk, .frame_sync_pulse, .port_transmit_line
);
